// >>> intc_accept.v
// interrupt request flags, priority selection, request pin and acceptance sequence
`timescale 1ns/1ps
`default_nettype none
`include "intc_accept_consts.vh"

module intc_accept #(
   // entry k (4 bits) holds the source index that has rank k, rank 0 highest
   parameter [51:0] RANK_TABLE = 52'hcba9876543210
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        hwStandby,
   input  wire [3:0]  dmaEndRequest,
   input  wire        infraredTransmitRequest,
   input  wire        infraredBreakRequest,
   input  wire        infraredReceiveRequest,
   input  wire        infraredErrorRequest,
   input  wire        conversionEndRequest,
   input  wire        fifoSerialTransmitRequest,
   input  wire        fifoSerialBreakRequest,
   input  wire        fifoSerialReceiveRequest,
   input  wire        fifoSerialErrorRequest,
   input  wire        instrBoundary,
   input  wire [31:0] programCounter,
   input  wire [7:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   input  wire [3:0]  byteenable,
   output reg  [31:0] readdata,
   output reg         waitrequest,
   output reg         requestOutN,
   output reg         takeInterrupt,
   output reg  [31:0] jumpTarget,
   output reg  [31:0] statusWord
);

   reg  [7:0]  requestFlagsFirst;
   reg  [7:0]  requestFlagsSecond;
   reg  [3:0]  prioDma;
   reg  [3:0]  prioInfrared;
   reg  [3:0]  prioFifoSerial;
   reg  [3:0]  prioConverter;
   reg  [31:0] savedStatusWord;
   reg  [31:0] savedProgramCounter;
   reg  [31:0] vectorBase;
   reg  [11:0] eventCode;
   reg  [11:0] eventCodeAlt;

   wire [12:0] pending;
   wire [3:0]  maskLevel;
   wire        blockFlag;
   wire [31:0] byteMask;
   wire        busWrite;

   reg  [3:0]  selLevel;
   reg  [3:0]  selSource;
   reg  [3:0]  srcLevel;
   reg  [3:0]  rankSrc;
   reg  [31:0] next_readdata;
   reg  [31:0] next_status;
   integer     k;

   // source index: 0..3 dma, 4..7 infrared err/rx/brk/tx, 8..11 fifo serial, 12 converter
   assign pending   = {requestFlagsSecond[4], requestFlagsSecond[3:0], requestFlagsFirst[7:0]};
   assign maskLevel = statusWord[`SW_MASK_LO+3:`SW_MASK_LO];
   assign blockFlag = statusWord[`SW_BLOCK_BIT];
   assign byteMask  = {{8{byteenable[3]}}, {8{byteenable[2]}},
                       {8{byteenable[1]}}, {8{byteenable[0]}}};
   // a write lands on the edge where the master sees waitrequest low
   assign busWrite  = write & ~waitrequest;

   // flag registers track the live request lines of the sources
   always @(posedge clk) begin
      if (rst) begin
         requestFlagsFirst  <= `RST_FLAGS;
         requestFlagsSecond <= `RST_FLAGS;
      end else begin
         requestFlagsFirst <= {infraredTransmitRequest, infraredBreakRequest,
                               infraredReceiveRequest, infraredErrorRequest,
                               dmaEndRequest};
         if (hwStandby) begin
            requestFlagsSecond <= `RST_FLAGS;
         end else begin
            requestFlagsSecond <= {3'b000, conversionEndRequest,
                                   fifoSerialTransmitRequest, fifoSerialBreakRequest,
                                   fifoSerialReceiveRequest, fifoSerialErrorRequest};
         end
      end
   end

   // priority selection; strict compare keeps the earlier rank on a tie
   always @* begin
      selLevel  = 4'h0;
      selSource = 4'h0;
      srcLevel  = 4'h0;
      rankSrc   = 4'h0;
      for (k = 0; k < `NUM_SOURCES; k = k + 1) begin
         rankSrc = RANK_TABLE[k*4 +: 4];
         if (rankSrc < 4'd4) begin
            srcLevel = prioDma;
         end else if (rankSrc < 4'd8) begin
            srcLevel = prioInfrared;
         end else if (rankSrc < 4'd12) begin
            srcLevel = prioFifoSerial;
         end else begin
            srcLevel = prioConverter;
         end
         if (pending[rankSrc] && (srcLevel > selLevel)) begin
            selLevel  = srcLevel;
            selSource = rankSrc;
         end
      end
   end

   // level 0 never exceeds any mask, so an empty selection is never accepted
   wire accept = selLevel > maskLevel;

   // read mux, address decode
   always @* begin
      next_readdata = 32'h00000000;
      if (address[7:2] == `OFS_FLAGS_FIRST >> 2) begin
         next_readdata = {24'h000000, requestFlagsFirst};
      end else if (address[7:2] == `OFS_FLAGS_SECOND >> 2) begin
         next_readdata = {24'h000000, requestFlagsSecond};
      end else if (address[7:2] == `OFS_PRIO_A >> 2) begin
         next_readdata = {28'h0000000, prioDma};
      end else if (address[7:2] == `OFS_PRIO_B >> 2) begin
         next_readdata = {28'h0000000, prioInfrared};
      end else if (address[7:2] == `OFS_PRIO_C >> 2) begin
         next_readdata = {28'h0000000, prioFifoSerial};
      end else if (address[7:2] == `OFS_PRIO_D >> 2) begin
         next_readdata = {28'h0000000, prioConverter};
      end else if (address[7:2] == `OFS_STATUS_WORD >> 2) begin
         next_readdata = statusWord;
      end else if (address[7:2] == `OFS_SAVED_STATUS >> 2) begin
         next_readdata = savedStatusWord;
      end else if (address[7:2] == `OFS_SAVED_PC >> 2) begin
         next_readdata = savedProgramCounter;
      end else if (address[7:2] == `OFS_VECTOR_BASE >> 2) begin
         next_readdata = vectorBase;
      end else if (address[7:2] == `OFS_EVENT_CODE >> 2) begin
         next_readdata = {20'h00000, eventCode};
      end else if (address[7:2] == `OFS_EVENT_CODE_ALT >> 2) begin
         next_readdata = {20'h00000, eventCodeAlt};
      end
   end

   // status word: software write first, then the taking of an interrupt on top
   always @* begin
      next_status = statusWord;
      if (busWrite && (address[7:2] == `OFS_STATUS_WORD >> 2)) begin
         next_status = (statusWord & ~byteMask) | (writedata & byteMask);
      end
      if (instrBoundary && accept && !blockFlag) begin
         // mask field untouched here
         next_status[`SW_BLOCK_BIT] = 1'b1;
         next_status[`SW_MODE_BIT]  = 1'b1;
         next_status[`SW_BANK_BIT]  = 1'b1;
      end
   end

   // bus slave: one wait cycle, answer on the second edge
   always @(posedge clk) begin
      if (rst) begin
         waitrequest <= 1'b1;
         readdata    <= `RST_WORD;
      end else begin
         waitrequest <= ~((read | write) & waitrequest);
         if (read && waitrequest) begin
            readdata <= next_readdata;
         end
      end
   end

   // writable registers
   always @(posedge clk) begin
      if (rst) begin
         prioDma        <= 4'h0;
         prioInfrared   <= 4'h0;
         prioFifoSerial <= 4'h0;
         prioConverter  <= 4'h0;
         vectorBase     <= `RST_WORD;
      end else if (busWrite && byteenable[0]) begin
         if (address[7:2] == `OFS_PRIO_A >> 2) begin
            prioDma <= writedata[3:0];
         end else if (address[7:2] == `OFS_PRIO_B >> 2) begin
            prioInfrared <= writedata[3:0];
         end else if (address[7:2] == `OFS_PRIO_C >> 2) begin
            prioFifoSerial <= writedata[3:0];
         end else if (address[7:2] == `OFS_PRIO_D >> 2) begin
            prioConverter <= writedata[3:0];
         end
      end
      if (!rst && busWrite && (address[7:2] == `OFS_VECTOR_BASE >> 2)) begin
         vectorBase <= (vectorBase & ~byteMask) | (writedata & byteMask);
      end
   end

   // request pin and acceptance sequence
   always @(posedge clk) begin
      if (rst) begin
         requestOutN         <= 1'b1;
         takeInterrupt       <= 1'b0;
         jumpTarget          <= `RST_WORD;
         statusWord          <= `RST_STATUS_WORD;
         savedStatusWord     <= `RST_WORD;
         savedProgramCounter <= `RST_WORD;
         eventCode           <= 12'h000;
         eventCodeAlt        <= 12'h000;
      end else begin
         // pin follows acceptance only, the block flag plays no part
         requestOutN   <= ~accept;
         takeInterrupt <= instrBoundary & accept & ~blockFlag;
         statusWord    <= next_status;
         if (busWrite && (address[7:2] == `OFS_SAVED_STATUS >> 2)) begin
            savedStatusWord <= (savedStatusWord & ~byteMask) | (writedata & byteMask);
         end
         if (busWrite && (address[7:2] == `OFS_SAVED_PC >> 2)) begin
            savedProgramCounter <= (savedProgramCounter & ~byteMask) | (writedata & byteMask);
         end
         if (instrBoundary && accept && !blockFlag) begin
            eventCode           <= `EVENT_CODE_BASE + {3'b000, selSource, 5'b00000};
            eventCodeAlt        <= `EVENT_CODE_BASE + {3'b000, selSource, 5'b00000};
            savedStatusWord     <= statusWord;
            savedProgramCounter <= programCounter;
            jumpTarget          <= vectorBase + `VECTOR_OFFSET;
         end
      end
   end

endmodule // intc_accept
`default_nettype wire

// >>> intc_accept_consts.vh
// constants for the interrupt acceptance and request flag block
// Notes on behaviour
// - first flag register bits 7..4 show infrared transmit, break, receive, error requests.
// - first flag register bits 3..0 show DMA channel 3..0 transfer-end requests.
// - first flag register clears on resets, keeps contents through software standby.
// - second flag register ignores writes; bits 7..5 always read zero.
// - second flag register bit 4 shows the converter conversion-end request.
// - second flag register bits 3..0 show FIFO serial transmit, break, receive, error.
// - second flag register clears on resets and hardware standby, not software standby.
// - highest priority level among requests is selected; lower ones stay pending.
// - equal levels are resolved by a fixed default rank.
// - selected request goes to the CPU only if its level exceeds the mask.
// - accepting a request drives the active-low request pin low.
// - request pin stays low until removal, returns high when masked.
// - request pin level ignores the exception-block flag.
// - the interrupt is taken only at an instruction boundary.
// - source code is written into both event code registers on taking.
// - status word saved to saved status, program counter to saved counter.
// - execution continues at vector base plus a fixed offset.
// - taking an interrupt leaves the mask level unchanged.
// - nesting: software saves context, clears block flag, raises mask; higher ones accepted.
// - while the block flag is one, taking an interrupt is held off.
`ifndef INTC_ACCEPT_CONSTS_VH
`define INTC_ACCEPT_CONSTS_VH

// byte offsets on the register bus
`define OFS_FLAGS_FIRST     8'h00
`define OFS_FLAGS_SECOND    8'h04
`define OFS_PRIO_A          8'h08
`define OFS_PRIO_B          8'h0c
`define OFS_PRIO_C          8'h10
`define OFS_PRIO_D          8'h14
`define OFS_STATUS_WORD     8'h18
`define OFS_SAVED_STATUS    8'h1c
`define OFS_SAVED_PC        8'h20
`define OFS_VECTOR_BASE     8'h24
`define OFS_EVENT_CODE      8'h28
`define OFS_EVENT_CODE_ALT  8'h2c

`define RST_FLAGS           8'h00
`define RST_WORD            32'h00000000
`define RST_STATUS_WORD     32'h70000000

// status word field positions
`define SW_MODE_BIT         30
`define SW_BANK_BIT         29
`define SW_BLOCK_BIT        28
`define SW_MASK_LO          4

`define VECTOR_OFFSET       32'h00000600
`define EVENT_CODE_BASE     12'h400
`define NUM_SOURCES         13

`endif

// >>> intc_accept_monitor.sv
// assertion checker for the interrupt acceptance block
`timescale 1ns/1ps
`default_nettype none
module intc_accept_monitor (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        instrBoundary,
   input wire logic        waitrequest,
   input wire logic        requestOutN,
   input wire logic        takeInterrupt,
   input wire logic [31:0] statusWord
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_wait_one: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low too long");
   a_take_once: assert property (takeInterrupt |=> !takeInterrupt)
      else $error("take is not a pulse");
   a_take_flags: assert property (takeInterrupt |-> statusWord[30:28] == 3'h7)
      else $error("flags not set on take");
   a_take_mask: assert property (takeInterrupt |-> statusWord[7:4] == $past(statusWord[7:4]))
      else $error("mask changed on take");
   a_take_boundary: assert property (takeInterrupt |-> $past(instrBoundary))
      else $error("take off a boundary");
   a_take_pin: assert property (takeInterrupt |-> !requestOutN)
      else $error("pin high on take");
   a_take_unblocked: assert property (takeInterrupt |-> !$past(statusWord[28]))
      else $error("take while blocked");
   a_masked_pin: assert property (statusWord[7:4] == 4'hf [*2] |=> requestOutN)
      else $error("pin low while masked");
   a_masked_take: assert property (statusWord[7:4] == 4'hf [*2] |=> !takeInterrupt)
      else $error("take while masked");
endmodule // intc_accept_monitor
bind intc_accept intc_accept_monitor intc_accept_monitor_i (.clk(clk), .rst(rst),
   .instrBoundary(instrBoundary), .waitrequest(waitrequest), .requestOutN(requestOutN),
   .takeInterrupt(takeInterrupt), .statusWord(statusWord));
`default_nettype wire

// >>> intc_sources.sv
// far-side model: request sources and core instruction boundary
`timescale 1ns/1ps
`default_nettype none
module intc_sources (
   input  wire logic        clk,
   input  wire logic        slow,
   input  wire logic [12:0] want,
   output var  logic [12:0] src,
   output var  logic        instrBoundary
);
   logic [1:0] phase = 2'h0;
   initial src = 13'h0;
   initial instrBoundary = 1'b1;
   always @(posedge clk) begin
      src <= want;
      phase <= phase + 2'h1;
      // slow core: long instructions, boundary one cycle in four
      instrBoundary <= !slow || phase == 2'h3;
   end
endmodule // intc_sources
`default_nettype wire

// >>> intc_accept_test.sv
// self-checking bench for the interrupt acceptance block
`timescale 1ns/1ps
`default_nettype none
module intc_accept_test;
   logic        clk = 1'b0, rst = 1'b1, hwStandby = 1'b0, read = 1'b0, write = 1'b0;
   logic        slow = 1'b0, waitrequest, requestOutN, takeInterrupt, instrBoundary;
   logic [7:0]  address = 8'h00;
   logic [31:0] writedata = 32'h0, programCounter = 32'h0, readdata, jumpTarget, statusWord;
   logic [31:0] q, vecBase;
   logic [12:0] want = 13'h0, src;
   int          fails = 0, n_compared = 0, lvl[4], n, b;
   intc_sources intc_sources_i (.clk(clk), .slow(slow), .want(want), .src(src),
      .instrBoundary(instrBoundary));
   intc_accept intc_accept_i (.clk(clk), .rst(rst), .hwStandby(hwStandby),
      .dmaEndRequest(src[3:0]), .infraredTransmitRequest(src[7]), .infraredBreakRequest(src[6]),
      .infraredReceiveRequest(src[5]), .infraredErrorRequest(src[4]),
      .conversionEndRequest(src[12]), .fifoSerialTransmitRequest(src[11]),
      .fifoSerialBreakRequest(src[10]), .fifoSerialReceiveRequest(src[9]),
      .fifoSerialErrorRequest(src[8]), .instrBoundary(instrBoundary),
      .programCounter(programCounter), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
      .waitrequest(waitrequest), .requestOutN(requestOutN), .takeInterrupt(takeInterrupt),
      .jumpTarget(jumpTarget), .statusWord(statusWord));
   initial forever #2 clk = !clk;
   initial begin
      #20000;
      fails++;
      test_done;
   end
   task test_done;
      if (fails == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         fails++;
         $display("unexpected at %0t: %h vs %h", $time, s, e);
      end
   endtask
   // request held until the rising edge that sees waitrequest low; read data taken there
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      read <= !w;
      write <= w;
      n = 0;
      do begin @(posedge clk); n++; end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) fails++;
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // one idle edge so the strobe is never reassigned in the same time step
      @(posedge clk);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task waitTake;
      n = 0;
      do begin @(negedge clk); n++; end while (takeInterrupt !== 1'b1 && n < 60);
      if (n >= 60) fails++;
      @(posedge clk);
   endtask
   // model: highest level above the mask, lowest index on a tie
   function automatic int best(logic [12:0] s, logic [3:0] m);
      int r = -1;
      for (int i = 0; i < 13; i++)
         if (s[i] && lvl[i / 4] > m && (r < 0 || lvl[i / 4] > lvl[r / 4])) r = i;
      return r;
   endfunction
   initial begin
      void'($urandom(32'hf378));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      rd(8'h3c, 32'h0);
      chk(statusWord, 32'h70000000);
      repeat (6) begin
         want <= 13'($urandom);
         repeat (3) @(posedge clk);
         rd(8'h00, {24'h0, want[7:0]});
         rd(8'h04, {27'h0, want[12:8]});
      end
      bus(1'b1, 8'h04, 32'hff);
      rd(8'h04, {27'h0, want[12:8]});
      hwStandby <= 1'b1;
      @(posedge clk);
      rd(8'h04, 32'h0);
      rd(8'h00, {24'h0, want[7:0]});
      hwStandby <= 1'b0;
      want <= 13'h0;
      lvl = '{3, 5, 5, 2};
      foreach (lvl[i]) bus(1'b1, 8'h08 + 8'(4 * i), 32'(lvl[i]));
      vecBase = $urandom & 32'hfffffc00;
      programCounter <= $urandom;
      bus(1'b1, 8'h24, vecBase);
      bus(1'b1, 8'h18, 32'h0);
      want <= 13'h0811;
      waitTake;
      b = best(13'h0811, 4'h0);
      chk(jumpTarget, vecBase + 32'h600);
      chk(requestOutN, 1'b0);
      rd(8'h28, 32'h400 + 32'(b) * 32'h20);
      rd(8'h2c, 32'h400 + 32'(b) * 32'h20);
      rd(8'h1c, 32'h0);
      rd(8'h20, programCounter);
      bus(1'b1, 8'h18, 32'h50);
      repeat (2) @(negedge clk);
      chk(requestOutN, 1'b1);
      @(posedge clk);
      lvl[3] = 7;
      bus(1'b1, 8'h14, 32'h7);
      slow <= 1'b1;
      want <= 13'h1811;
      waitTake;
      b = best(13'h1811, 4'h5);
      rd(8'h28, 32'h400 + 32'(b) * 32'h20);
      rd(8'h1c, 32'h50);
      chk(statusWord, 32'h70000050);
      bus(1'b1, 8'h18, 32'hf0);
      repeat (3) @(negedge clk);
      chk(requestOutN, 1'b1);
      @(posedge clk);
      want <= 13'h0;
      repeat (3) @(posedge clk);
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      // handler done: unblock at the lowest mask, nothing may be taken again
      bus(1'b1, 8'h18, 32'h0);
      repeat (4) begin
         @(negedge clk);
         chk(takeInterrupt, 1'b0);
      end
      chk(requestOutN, 1'b1);
      @(posedge clk);
      rd(8'h28, 32'h400 + 32'(b) * 32'h20);
      test_done;
   end
endmodule // intc_accept_test
`default_nettype wire
